/* design/usx_pkg.sv */
package usx_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_SD_CFG   = 8'h00;
    localparam logic [7:0] OFS_LOCK_ST  = 8'h04;
    localparam logic [7:0] OFS_PORT_RST = 8'h08;
    localparam logic [7:0] OFS_RADAPT   = 8'h0c;
    localparam logic [7:0] OFS_IRQ_ST   = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    // signal_detect_config fields
    localparam int SIGNAL_DETECT_POLARITY_BIT = 0;
    localparam int SD_USE_BIT = 1;
    // pcs_lock_status fields
    localparam int LOCK_BIT   = 0;
    localparam int SIGDET_BIT = 1;
    localparam int LEVEL_LSB  = 8;
    // port_reset_control fields
    localparam int OWDIS_BIT  = 0;
    localparam int SPEED_LSB  = 4;
    // tx_rate_adapt_config fields
    localparam int GAP_LSB    = 0;
    localparam int ADD_LSB    = 8;
    localparam int DROP_LSB   = 16;
    localparam int LFDIS_BIT  = 24;
    // Interrupt status bits
    localparam int EV_SIG_LOST  = 0;
    localparam int EV_LOCK_LOST = 1;
    localparam int EV_ADD       = 2;
    localparam int EV_DROP      = 3;
    // Reset values
    localparam logic       RST_SIGNAL_DETECT_POLARITY   = 1'b1;
    localparam logic       RST_SD_USE   = 1'b0;
    localparam logic       RST_OW_DIS   = 1'b0;
    localparam logic [2:0] RST_SPEED    = 3'h5;
    localparam logic [1:0] RST_MIN_GAP  = 2'h1;
    localparam logic [3:0] RST_ADD_LVL  = 4'h4;
    localparam logic [3:0] RST_DROP_LVL = 4'h8;
    localparam logic       RST_LF_DIS   = 1'b0;
    // Speed codes
    localparam logic [2:0] SPD_10M  = 3'h0;
    localparam logic [2:0] SPD_100M = 3'h1;
    localparam logic [2:0] SPD_1G   = 3'h2;
    localparam logic [2:0] SPD_2G5  = 3'h3;
    localparam logic [2:0] SPD_5G   = 3'h4;
    // Replications per XGMII word, less one
    localparam logic [9:0] REP_10M  = 10'h3e7;
    localparam logic [9:0] REP_100M = 10'h063;
    localparam logic [9:0] REP_1G   = 10'h009;
    localparam logic [9:0] REP_2G5  = 10'h003;
    localparam logic [9:0] REP_5G   = 10'h001;
    localparam logic [9:0] REP_10G  = 10'h000;
    // XGMII control characters and ordered sets
    localparam logic [7:0] CH_IDLE  = 8'h07;
    localparam logic [7:0] CH_START = 8'hfb;
    localparam logic [7:0] CH_TERM  = 8'hfd;
    localparam logic [7:0] CH_SEQ   = 8'h9c;
    localparam logic [7:0] SEQ_LF   = 8'h01;
    localparam logic [7:0] SEQ_RF   = 8'h02;
    localparam logic [71:0] W_IDLE  = 72'hff_0707070707070707;
    localparam logic [71:0] W_LF    = 72'h11_0100009c_0100009c;
    // Each idle word carries two 4-byte transactions
    localparam logic [2:0] TRANS_PER_WORD = 3'h2;
endpackage

/* design/usx_pcs.sv */
`timescale 1ns/1ns
// How it works
// - Runs at 10, 100, 1000, 2500, 5000 and 10000 Mbps, full duplex only.
// - With the pin in use, signal counts as detected only when the pin level equals the polarity.
// - Signal-detect use 0 ignores the pin; 1 lets the pin decide presence.
// - Auto-negotiation restarts whenever no signal is present.
// - Read-only block-lock flag shows 1 while the receiver holds block lock.
// - At lower rates keep the first word of each replicated group only.
// - Discarded local or remote fault overwrites next word unless disabled.
// - While dropping, keep whole idle words until at least the minimum gap (0 to 3 transactions) follows each terminate.
// - Programmable add threshold, in 72-bit words of FIFO fill.
// - Programmable drop threshold, in 72-bit words of FIFO fill.
// - Send local fault while not aligned unless generation is disabled.

module usx_pcs #(
    parameter int DEPTH = 16
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             irq_o,
    input  wire logic        signal_detect_i,
    input  wire logic        block_lock_i,
    output logic             aneg_restart_o,
    input  wire logic        rx_valid_i,
    input  wire logic [63:0] rx_data_i,
    input  wire logic [7:0]  rx_ctrl_i,
    output logic             rx_valid_o,
    output logic      [63:0] rx_data_o,
    output logic      [7:0]  rx_ctrl_o,
    input  wire logic        tx_valid_i,
    input  wire logic [63:0] tx_data_i,
    input  wire logic [7:0]  tx_ctrl_i,
    output logic             tx_ready_o,
    output logic             tx_valid_o,
    output logic      [63:0] tx_data_o,
    output logic      [7:0]  tx_ctrl_o,
    input  wire logic        tx_ready_i
);
    localparam int AW = $clog2(DEPTH);

    // Levels are 4-bit fields, so the FIFO must hold at least 16 words
    if (DEPTH < 16 || DEPTH != (1 << AW)) begin : g_chk
        $error("DEPTH must be a power of two of at least 16");
    end

    typedef struct packed {
        // Pin sync and configuration
        logic [1:0]              sd_sync;
        logic                    signal_detect_polarity;
        logic                    sd_use;
        logic                    ow_dis;
        logic [2:0]              speed;
        logic [1:0]              min_gap;
        logic [3:0]              add_lvl;
        logic [3:0]              drop_lvl;
        logic                    lf_dis;
        // Bus and interrupts
        logic [3:0]              irq_st;
        logic [3:0]              irq_mask;
        logic                    irq;
        logic                    ack;
        logic [31:0]             rdata;
        // Signal and lock watch
        logic                    aneg;
        logic                    sig_prev;
        logic                    lock_prev;
        // Receive replicator
        logic [9:0]              rep_cnt;
        logic                    flt_pend;
        logic [71:0]             flt_word;
        logic                    rx_vld;
        logic [71:0]             rx_word;
        // Transmit FIFO
        logic [DEPTH-1:0][71:0]  mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic                    in_rdy;
        logic [2:0]              gap;
        logic                    out_fr;
        logic                    tx_vld;
        logic [71:0]             tx_word;
    } usx_state_t;

    usx_state_t s_ff;
    usx_state_t nxt_s;

    function automatic logic [9:0] rep_last(input logic [2:0] spd);
        case (spd)
            usx_pkg::SPD_10M:  rep_last = usx_pkg::REP_10M;
            usx_pkg::SPD_100M: rep_last = usx_pkg::REP_100M;
            usx_pkg::SPD_1G:   rep_last = usx_pkg::REP_1G;
            usx_pkg::SPD_2G5:  rep_last = usx_pkg::REP_2G5;
            usx_pkg::SPD_5G:   rep_last = usx_pkg::REP_5G;
            default:           rep_last = usx_pkg::REP_10G;
        endcase
    endfunction

    function automatic logic is_idle(input logic [71:0] w);
        is_idle = (w == usx_pkg::W_IDLE);
    endfunction

    function automatic logic has_ctl(input logic [71:0] w, input logic [7:0] ch);
        logic hit;
        hit = 1'b0;

        for (int i = 0; i < 8; i++) begin
            if (w[64+i] && w[8*i +: 8] == ch) begin
                hit = 1'b1;
            end
        end
        has_ctl = hit;
    endfunction

    function automatic logic is_fault(input logic [71:0] w);
        is_fault = w[64] && w[7:0] == usx_pkg::CH_SEQ
                   && (w[31:24] == usx_pkg::SEQ_LF || w[31:24] == usx_pkg::SEQ_RF);
    endfunction

    function automatic logic [31:0] reg_rd(input usx_state_t s, input logic [7:0] a,
                                           input logic sig, input logic lock);
        logic [31:0] v;
        v = 32'h0000_0000;

        case (a)
            usx_pkg::OFS_SD_CFG: begin
                v[usx_pkg::SIGNAL_DETECT_POLARITY_BIT] = s.signal_detect_polarity;
                v[usx_pkg::SD_USE_BIT] = s.sd_use;
            end
            usx_pkg::OFS_LOCK_ST: begin
                v[usx_pkg::LOCK_BIT]   = lock;
                v[usx_pkg::SIGDET_BIT] = sig;
                v[usx_pkg::LEVEL_LSB +: AW+1] = s.cnt;
            end
            usx_pkg::OFS_PORT_RST: begin
                v[usx_pkg::OWDIS_BIT]      = s.ow_dis;
                v[usx_pkg::SPEED_LSB +: 3] = s.speed;
            end
            usx_pkg::OFS_RADAPT: begin
                v[usx_pkg::GAP_LSB +: 2]  = s.min_gap;
                v[usx_pkg::ADD_LSB +: 4]  = s.add_lvl;
                v[usx_pkg::DROP_LSB +: 4] = s.drop_lvl;
                v[usx_pkg::LFDIS_BIT]     = s.lf_dis;
            end
            usx_pkg::OFS_IRQ_ST:   v[3:0] = s.irq_st;
            usx_pkg::OFS_IRQ_MASK: v[3:0] = s.irq_mask;
            default:               v = 32'h0000_0000;
        endcase

        reg_rd = v;
    endfunction

    logic        sig_ok;
    logic        lock;
    logic        req;
    logic        commit;
    logic [31:0] be_mask;
    logic [31:0] wv;
    logic [3:0]  ev;
    logic [71:0] in_w;
    logic [71:0] rx_in;
    logic        push;
    logic        keep;
    logic        pop;
    logic [71:0] head;

    always_comb begin
        nxt_s = s_ff;
        ev    = 4'h0;

        // Receiver lock shares this clock: no sync
        lock  = block_lock_i;
        // Without the pin in use the signal is always taken as present
        sig_ok = s_ff.sd_use ? (s_ff.sd_sync[1] == s_ff.signal_detect_polarity) : 1'b1;
        nxt_s.sd_sync = {s_ff.sd_sync[0], signal_detect_i};
        nxt_s.aneg    = !sig_ok;
        nxt_s.sig_prev  = sig_ok;
        nxt_s.lock_prev = lock;
        ev[usx_pkg::EV_SIG_LOST]  = s_ff.sig_prev && !sig_ok;
        ev[usx_pkg::EV_LOCK_LOST] = s_ff.lock_prev && !lock;

        // Bus: request seen, then one cycle with waitrequest low
        req     = (avs_read_i || avs_write_i) && !s_ff.ack;
        commit  = s_ff.ack && (avs_read_i || avs_write_i);
        nxt_s.ack = req;
        if (req) begin
            nxt_s.rdata = reg_rd(s_ff, avs_address_i, sig_ok, lock);
        end

        for (int i = 0; i < 4; i++) begin
            be_mask[8*i +: 8] = {8{avs_byteenable_i[i]}};
        end

        wv = (reg_rd(s_ff, avs_address_i, sig_ok, lock) & ~be_mask)
             | (avs_writedata_i & be_mask);

        if (commit && avs_write_i) begin
            case (avs_address_i)
                usx_pkg::OFS_SD_CFG: begin
                    nxt_s.signal_detect_polarity = wv[usx_pkg::SIGNAL_DETECT_POLARITY_BIT];
                    nxt_s.sd_use = wv[usx_pkg::SD_USE_BIT];
                end
                usx_pkg::OFS_PORT_RST: begin
                    nxt_s.ow_dis = wv[usx_pkg::OWDIS_BIT];
                    nxt_s.speed  = wv[usx_pkg::SPEED_LSB +: 3];
                end
                usx_pkg::OFS_RADAPT: begin
                    nxt_s.min_gap  = wv[usx_pkg::GAP_LSB +: 2];
                    nxt_s.add_lvl  = wv[usx_pkg::ADD_LSB +: 4];
                    nxt_s.drop_lvl = wv[usx_pkg::DROP_LSB +: 4];
                    nxt_s.lf_dis   = wv[usx_pkg::LFDIS_BIT];
                end
                usx_pkg::OFS_IRQ_MASK: nxt_s.irq_mask = wv[3:0];
                default: nxt_s.irq_mask = s_ff.irq_mask;
            endcase
        end

        // Receive replicator
        rx_in = {rx_ctrl_i, rx_data_i};
        nxt_s.rx_vld = 1'b0;

        if (rx_valid_i) begin
            nxt_s.rep_cnt = (s_ff.rep_cnt >= rep_last(s_ff.speed)) ? 10'h000
                            : s_ff.rep_cnt + 10'h001;
            if (s_ff.rep_cnt == 10'h000) begin
                nxt_s.rx_vld  = 1'b1;
                nxt_s.rx_word = rx_in;
                if (s_ff.flt_pend && !s_ff.ow_dis) begin
                    nxt_s.rx_word = s_ff.flt_word;
                end
                nxt_s.flt_pend = 1'b0;
            end else if (is_fault(rx_in)) begin
                nxt_s.flt_pend = 1'b1;
                nxt_s.flt_word = rx_in;
            end
        end

        // Transmit rate-adaptation FIFO, write side
        in_w = {tx_ctrl_i, tx_data_i};
        push = tx_valid_i && s_ff.in_rdy;
        keep = push;

        if (push) begin
            if (has_ctl(in_w, usx_pkg::CH_TERM)) begin
                nxt_s.gap = 3'h0;
            end else if (is_idle(in_w)) begin
                // Idle beyond the kept gap is dropped when too full
                if (s_ff.cnt > (AW+1)'(s_ff.drop_lvl)
                    && s_ff.gap >= {1'b0, s_ff.min_gap}) begin
                    keep = 1'b0;
                    ev[usx_pkg::EV_DROP] = 1'b1;
                end else if (s_ff.gap < 3'h4) begin
                    nxt_s.gap = s_ff.gap + usx_pkg::TRANS_PER_WORD;
                end
            end
        end

        if (keep) begin
            nxt_s.mem[s_ff.wp] = in_w;
            nxt_s.wp = s_ff.wp + AW'(1);
        end

        // Read side into the output register
        pop  = 1'b0;
        head = s_ff.mem[s_ff.rp];

        if (!s_ff.tx_vld || tx_ready_i) begin
            nxt_s.tx_vld = 1'b1;
            if (!lock && !s_ff.lf_dis) begin
                nxt_s.tx_word = usx_pkg::W_LF;
            end else if (s_ff.cnt == '0
                         || (s_ff.cnt < (AW+1)'(s_ff.add_lvl) && !s_ff.out_fr)) begin
                // Below the add level, adding only between frames; an empty FIFO adds idle even mid-frame
                nxt_s.tx_word = usx_pkg::W_IDLE;
                ev[usx_pkg::EV_ADD] = 1'b1;
            end else begin
                pop = 1'b1;
                nxt_s.tx_word = head;
                nxt_s.rp = s_ff.rp + AW'(1);
                if (has_ctl(head, usx_pkg::CH_TERM)) begin
                    nxt_s.out_fr = 1'b0;
                end else if (has_ctl(head, usx_pkg::CH_START)) begin
                    nxt_s.out_fr = 1'b1;
                end
            end
        end

        nxt_s.cnt = s_ff.cnt + (AW+1)'(keep) - (AW+1)'(pop);
        // Ready leaves one word of slack for the push in flight
        nxt_s.in_rdy = nxt_s.cnt < (AW+1)'(DEPTH - 1);

        // Interrupts: a new event beats the read that clears
        if (commit && avs_read_i && avs_address_i == usx_pkg::OFS_IRQ_ST) begin
            nxt_s.irq_st = 4'h0;
        end
        nxt_s.irq_st = nxt_s.irq_st | ev;
        nxt_s.irq    = |(nxt_s.irq_st & nxt_s.irq_mask);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_ff          <= '0;

            s_ff.signal_detect_polarity   <= usx_pkg::RST_SIGNAL_DETECT_POLARITY;
            s_ff.sd_use   <= usx_pkg::RST_SD_USE;
            s_ff.ow_dis   <= usx_pkg::RST_OW_DIS;
            s_ff.speed    <= usx_pkg::RST_SPEED;
            s_ff.min_gap  <= usx_pkg::RST_MIN_GAP;
            s_ff.add_lvl  <= usx_pkg::RST_ADD_LVL;
            s_ff.drop_lvl <= usx_pkg::RST_DROP_LVL;
            s_ff.lf_dis   <= usx_pkg::RST_LF_DIS;
            s_ff.in_rdy   <= 1'b1;
            s_ff.sig_prev <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign avs_readdata_o    = s_ff.rdata;
    assign avs_waitrequest_o = !s_ff.ack;
    assign irq_o             = s_ff.irq;
    assign aneg_restart_o    = s_ff.aneg;
    assign rx_valid_o        = s_ff.rx_vld;
    assign rx_data_o         = s_ff.rx_word[63:0];
    assign rx_ctrl_o         = s_ff.rx_word[71:64];
    assign tx_ready_o        = s_ff.in_rdy;
    assign tx_valid_o        = s_ff.tx_vld;
    assign tx_data_o         = s_ff.tx_word[63:0];
    assign tx_ctrl_o         = s_ff.tx_word[71:64];

endmodule

/* sim/usx_pcs_checker.sv */
`timescale 1ns/1ns
module usx_pcs_checker (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        signal_detect_i,
    input wire logic        block_lock_i,
    input wire logic        aneg_restart_o,
    input wire logic        rx_valid_i,
    input wire logic        rx_valid_o,
    input wire logic        tx_valid_o,
    input wire logic [63:0] tx_data_o,
    input wire logic [7:0]  tx_ctrl_o,
    input wire logic        tx_ready_i
);
    // Shadows of the config bits, updated at the same edge as the design
    logic pol_ff, use_ff, lfd_ff, wr_ok, absent;
    logic [1:0] sd_ff;
    assign wr_ok  = avs_write_i && !avs_waitrequest_o;
    assign absent = use_ff && (sd_ff[1] != pol_ff);
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pol_ff <= usx_pkg::RST_SIGNAL_DETECT_POLARITY;
            use_ff <= usx_pkg::RST_SD_USE;
            lfd_ff <= usx_pkg::RST_LF_DIS;
            sd_ff  <= 2'h0;
        end else begin
            sd_ff  <= {sd_ff[0], signal_detect_i};
            if (wr_ok && avs_byteenable_i[0] && avs_address_i == usx_pkg::OFS_SD_CFG) begin
                pol_ff <= avs_writedata_i[usx_pkg::SIGNAL_DETECT_POLARITY_BIT];
                use_ff <= avs_writedata_i[usx_pkg::SD_USE_BIT];
            end
            if (wr_ok && avs_byteenable_i[3] && avs_address_i == usx_pkg::OFS_RADAPT) begin
                lfd_ff <= avs_writedata_i[usx_pkg::LFDIS_BIT];
            end
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("bus answer late");
    property p_ack_once; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("bus answer too long");
    property p_lost; absent |=> aneg_restart_o; endproperty
    a_lost: assert property (p_lost) else $error("no restart on lost signal");
    property p_found; !absent |=> !aneg_restart_o; endproperty
    a_found: assert property (p_found) else $error("restart with signal present");
    property p_lock; avs_read_i && avs_waitrequest_o && avs_address_i == usx_pkg::OFS_LOCK_ST
        |=> avs_readdata_o[usx_pkg::LOCK_BIT] == $past(block_lock_i); endproperty
    a_lock: assert property (p_lock) else $error("lock flag wrong");
    property p_lf; tx_valid_o && tx_ready_i && !block_lock_i && !lfd_ff
        |=> {tx_ctrl_o, tx_data_o} == usx_pkg::W_LF; endproperty
    a_lf: assert property (p_lf) else $error("local fault not sent");
    property p_rx; rx_valid_o |-> $past(rx_valid_i); endproperty
    a_rx: assert property (p_rx) else $error("kept word without input");
    property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_ctrl_o, tx_data_o}); endproperty
    a_hold: assert property (p_hold) else $error("tx word changed while stalled");
    property p_fill; tx_valid_o |=> tx_valid_o; endproperty
    a_fill: assert property (p_fill) else $error("tx gap without idle");
endmodule
bind usx_pcs usx_pcs_checker usx_pcs_checker_inst (.sys_clk_i, .rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .signal_detect_i, .block_lock_i, .aneg_restart_o, .rx_valid_i,
    .rx_valid_o, .tx_valid_o, .tx_data_o, .tx_ctrl_o, .tx_ready_i);

/* sim/usx_line_model.sv */
`timescale 1ns/1ns
module usx_line_model (
    input  wire logic        sys_clk_i,
    input  wire logic        stall_i,
    input  wire logic        tx_valid_i,
    input  wire logic [63:0] tx_data_i,
    input  wire logic [7:0]  tx_ctrl_i,
    output logic             tx_ready_o,
    output logic             rx_valid_o,
    output logic      [63:0] rx_data_o,
    output logic      [7:0]  rx_ctrl_o,
    output logic      [71:0] last_o,
    output logic      [7:0]  gap_o
);
    logic [7:0] run;
    initial begin
        {tx_ready_o, rx_valid_o, last_o, gap_o, run} = {1'b1, 89'h0};
        {rx_ctrl_o, rx_data_o} = '1;
    end
    // Idle words seen since the last terminate, latched at the next start
    always @(posedge sys_clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            last_o <= {tx_ctrl_i, tx_data_i};
            if ({tx_ctrl_i, tx_data_i} == usx_pkg::W_IDLE) run <= run + 8'h1;
            if (tx_ctrl_i[0] && tx_data_i[7:0] == usx_pkg::CH_START) gap_o <= run;
            if (tx_ctrl_i[0] && tx_data_i[7:0] == usx_pkg::CH_TERM) run <= 8'h0;
        end
        tx_ready_o <= !stall_i && ($urandom_range(3) != 0);
    end
    // Replicated group; between groups the lines carry the inverse, not the old word
    task automatic send(input logic [71:0] x, input int reps);
        repeat (reps) begin
            @(posedge sys_clk_i);
            rx_valid_o <= 1'b1;
            {rx_ctrl_o, rx_data_o} <= x;
        end
        @(posedge sys_clk_i);
        rx_valid_o <= 1'b0;
        {rx_ctrl_o, rx_data_o} <= ~x;
    endtask
endmodule

/* sim/test_usx_pcs.sv */
`timescale 1ns/1ns
module test_usx_pcs;
    localparam int DEPTH = 16;
    logic        sys_clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
    logic        signal_detect_i, block_lock_i, aneg_restart_o, stall;
    logic        rx_valid_i, rx_valid_o, tx_valid_i, tx_ready_o, tx_valid_o, tx_ready_i;
    logic [7:0]  avs_address_i, rx_ctrl_i, rx_ctrl_o, tx_ctrl_i, tx_ctrl_o, gap_w;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [63:0] rx_data_i, rx_data_o, tx_data_i, tx_data_o;
    logic [71:0] last_w, w, f, exp_q[$];
    int          num_errors = 0, cmp_count = 0, n;
    usx_pcs #(.DEPTH(DEPTH)) usx_pcs_inst (.sys_clk_i, .rst_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o,
        .avs_waitrequest_o, .irq_o, .signal_detect_i, .block_lock_i, .aneg_restart_o,
        .rx_valid_i, .rx_data_i, .rx_ctrl_i, .rx_valid_o, .rx_data_o, .rx_ctrl_o, .tx_valid_i,
        .tx_data_i, .tx_ctrl_i, .tx_ready_o, .tx_valid_o, .tx_data_o, .tx_ctrl_o, .tx_ready_i);
    usx_line_model usx_line_model_inst (.sys_clk_i, .stall_i(stall), .tx_valid_i(tx_valid_o),
        .tx_data_i(tx_data_o), .tx_ctrl_i(tx_ctrl_o), .tx_ready_o(tx_ready_i),
        .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_ctrl_o(rx_ctrl_i), .last_o(last_w),
        .gap_o(gap_w));
    task automatic finish_test();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        num_errors++;
        $display("wait expired at %0t", $time);
        finish_test();
    endtask
    // An idle edge first, so a request never rises in the step that released the last one
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk_i);
        {avs_address_i, avs_writedata_i, avs_write_i, avs_read_i} <= {a, d, wr, !wr};
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 20);
        q = avs_readdata_o;
        {avs_write_i, avs_read_i} <= 2'b00;
        if (k >= 20) hang();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp(q & m, e);
    endtask
    task automatic push(input logic [71:0] x);
        int k;
        k = 0;
        {tx_valid_i, tx_ctrl_i, tx_data_i} <= {1'b1, x};
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (tx_ready_o !== 1'b1 && k < 50);
        if (k >= 50) hang();
    endtask
    function automatic logic [31:0] ra(logic [1:0] g, logic [3:0] ad, logic [3:0] dr, logic lf);
        return {7'h0, lf, 4'h0, dr, 4'h0, ad, 6'h0, g};
    endfunction
    function automatic logic [31:0] pc(logic ow, logic [2:0] spd);
        return {25'h0, spd, 3'h0, ow};
    endfunction
    function automatic int gn(logic [2:0] spd);
        case (spd)
            3'h0: return 1000;
            3'h1: return 100;
            3'h2: return 10;
            3'h3: return 4;
            3'h4: return 2;
            default: return 1;
        endcase
    endfunction
    always @(posedge sys_clk_i) begin
        if (rx_valid_o === 1'b1) begin
            cmp({rx_ctrl_o, rx_data_o}, exp_q.size() > 0 ? exp_q.pop_front() : 72'hx);
        end
    end
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        {rst_i, block_lock_i, avs_read_i, avs_write_i, tx_valid_i, stall, signal_detect_i} = 7'h60;
        {avs_address_i, avs_writedata_i, tx_ctrl_i, tx_data_i} = '0;
        q = $urandom(44);
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdc(usx_pkg::OFS_SD_CFG, '1, {30'h0, usx_pkg::RST_SD_USE, usx_pkg::RST_SIGNAL_DETECT_POLARITY});
        rdc(usx_pkg::OFS_PORT_RST, '1, pc(usx_pkg::RST_OW_DIS, usx_pkg::RST_SPEED));
        rdc(usx_pkg::OFS_RADAPT, '1, ra(usx_pkg::RST_MIN_GAP, usx_pkg::RST_ADD_LVL,
            usx_pkg::RST_DROP_LVL, usx_pkg::RST_LF_DIS));
        bus(1'b1, 8'h20, '1);
        rdc(8'h20, '1, 32'h0);
        bus(1'b1, usx_pkg::OFS_RADAPT, ra(2'h1, 4'h4, 4'h8, 1'b0));
        rdc(usx_pkg::OFS_RADAPT, '1, ra(2'h1, 4'h4, 4'h8, 1'b0));
        block_lock_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        cmp(last_w, usx_pkg::W_LF);
        rdc(usx_pkg::OFS_LOCK_ST, 32'h1, 32'h0);
        bus(1'b1, usx_pkg::OFS_RADAPT, ra(2'h1, 4'h4, 4'h8, 1'b1));
        repeat (8) @(posedge sys_clk_i);
        cmp(last_w, usx_pkg::W_IDLE);
        bus(1'b1, usx_pkg::OFS_RADAPT, ra(2'h1, 4'h4, 4'h8, 1'b0));
        block_lock_i <= 1'b1;
        rdc(usx_pkg::OFS_LOCK_ST, 32'h1, 32'h1);
        bus(1'b1, usx_pkg::OFS_IRQ_MASK, 32'h1);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, usx_pkg::OFS_SD_CFG, {30'h0, i[2], i[1]});
            signal_detect_i <= i[0];
            repeat (4) @(posedge sys_clk_i);
            cmp(aneg_restart_o, i[2] && (i[0] != i[1]));
        end
        cmp(irq_o, 1'b1);
        rdc(usx_pkg::OFS_IRQ_ST, 32'h5, 32'h5);
        rdc(usx_pkg::OFS_IRQ_ST, 32'h1, 32'h0);
        cmp(irq_o, 1'b0);
        bus(1'b1, usx_pkg::OFS_IRQ_MASK, 32'h0);
        signal_detect_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        cmp(irq_o, 1'b0);
        signal_detect_i <= 1'b1;
        rdc(usx_pkg::OFS_IRQ_ST, 32'h1, 32'h1);
        for (int s = 0; s < 6; s++) begin
            bus(1'b1, usx_pkg::OFS_PORT_RST, pc(1'b0, s[2:0]));
            for (int g = 0; g < 3; g++) begin
                w = {8'h0, $urandom(), $urandom()};
                exp_q.push_back(w);
                usx_line_model_inst.send(w, gn(s[2:0]));
            end
        end
        // Fault rides in the dropped second word; one run with overwrite disabled
        for (int o = 0; o < 3; o++) begin
            bus(1'b1, usx_pkg::OFS_PORT_RST, pc(o[1], usx_pkg::SPD_5G));
            {w, f} = {8'h0, $urandom(), $urandom(), usx_pkg::W_LF};
            if (o[0]) {f[63:56], f[31:24]} = {2{usx_pkg::SEQ_RF}};
            exp_q.push_back(w);
            usx_line_model_inst.send(w, 1);
            usx_line_model_inst.send(f, 1);
            w = {8'h0, $urandom(), $urandom()};
            exp_q.push_back(o[1] ? w : f);
            usx_line_model_inst.send(w, 2);
        end
        stall <= 1'b1;
        bus(1'b0, usx_pkg::OFS_IRQ_ST, 32'h0);
        push({8'h01, 24'h0, $urandom(), usx_pkg::CH_START});
        repeat (8) push({8'h0, $urandom(), $urandom()});
        push({8'hff, 56'h07070707070707, usx_pkg::CH_TERM});
        repeat (4) push(usx_pkg::W_IDLE);
        push({8'h01, 24'h0, $urandom(), usx_pkg::CH_START});
        repeat (3) push({8'h0, $urandom(), $urandom()});
        {tx_valid_i, stall} <= 2'b00;
        repeat (60) @(posedge sys_clk_i);
        cmp(gap_w, 8'h1);
        rdc(usx_pkg::OFS_IRQ_ST, 32'h8, 32'h8);
        stall <= 1'b1;
        n = 0;
        repeat (2) @(posedge sys_clk_i);
        tx_valid_i <= 1'b1;
        for (int k = 0; k < 20 && n == k; k++) begin
            {tx_ctrl_i, tx_data_i} <= {8'h0, $urandom(), $urandom()};
            @(posedge sys_clk_i);
            if (tx_ready_o === 1'b1) n++;
        end
        tx_valid_i <= 1'b0;
        cmp(n, DEPTH - 1);
        rdc(usx_pkg::OFS_LOCK_ST, 32'h1f00, (DEPTH - 1) << usx_pkg::LEVEL_LSB);
        stall <= 1'b0;
        repeat (60) @(posedge sys_clk_i);
        cmp(exp_q.size(), 0);
        finish_test();
    end
endmodule
